/* design/irq_pkg.sv */
package irq_pkg;
	localparam int NUM_SRC = 17;
	localparam int SRC_W = 5;
	localparam int VEC_W = 16;
	localparam int PIN_W = 8;
	localparam int PSEL_W = 3;
	// source indices, lowest index wins among equal levels
	localparam int SRC_EXT0 = 0;
	localparam int SRC_EXT1 = 2;
	// flags cleared by hardware on vectoring: ext0, timer0, ext1, timer1
	localparam logic [NUM_SRC-1:0] HW_CLEAR_MASK = 17'h0000f;
	localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
	localparam int VEC_STEP_SHIFT = 3;
	// register byte offsets
	localparam logic [7:0] REG_ENABLE = 8'h00;
	localparam logic [7:0] REG_GLOBAL = 8'h04;
	localparam logic [7:0] REG_PRIORITY = 8'h08;
	localparam logic [7:0] REG_PENDING = 8'h0c;
	localparam logic [7:0] REG_EXT_CFG = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	// ext config field positions
	localparam int CFG_EXT0_EDGE = 0;
	localparam int CFG_EXT1_EDGE = 1;
	localparam int CFG_EXT0_POL = 2;
	localparam int CFG_EXT1_POL = 3;
	localparam int CFG_EXT0_PSEL = 4;
	localparam int CFG_EXT1_PSEL = 8;
	localparam int CFG_W = 11;
	localparam logic [CFG_W-1:0] EXT_CFG_RST = 11'h000;
	localparam logic [NUM_SRC-1:0] PRIORITY_RST = 17'h00000;
	localparam logic [NUM_SRC-1:0] ENABLE_RST = 17'h00000;
	// status field positions
	localparam int ST_LOW_ACT = 0;
	localparam int ST_HIGH_ACT = 1;
	localparam int ST_REQ = 2;
	localparam int ST_SRC = 8;
	// cycles for the vector call after acknowledge
	localparam int CALL_CYCLES = 5;
	localparam int CALL_CNT_W = 3;
	localparam logic [CALL_CNT_W-1:0] CALL_LAST = 3'h4;
endpackage

/* design/irq_if.sv */
`timescale 1ns/1ps
interface irq_if;
	logic req;
	logic [irq_pkg::VEC_W-1:0] vector;
	logic [irq_pkg::SRC_W-1:0] src;
	logic src_high;
	logic ack;
	logic return_from_isr;
	logic instr_done;
	modport dev (output req, output vector, output src, output src_high, input ack, input return_from_isr, input instr_done);
	modport cpu (input req, input vector, input src, input src_high, output ack, output return_from_isr, output instr_done);
endinterface

/* design/irq_handler.sv */
`timescale 1ns/1ps
// Functional notes
// RULE1: source event sets pending flag regardless of enable
// RULE2: enabled pending flag raises request, vector call
// RULE3: service routine ends with return, resumes flow
// RULE4: disabled source pending flag ignored
// RULE5: global enable gates all individual enables
// RULE6: some flags auto-clear on vectoring, others software
// RULE7: flag still set after return requests again
// RULE8: software setting a flag acts as interrupt
// RULE9: external inputs selectable edge/level and polarity
// RULE10: pin select register picks monitored port pin
// RULE11: software should skip pin, open-drain latch one
// RULE12: edge mode external flag cleared on vectoring
// RULE13: level mode external flag follows active input
// RULE14: level source holds input until recognized
// RULE15: two priority levels, high preempts low only
// RULE16: all priority bits reset to low
// RULE17: higher level first, then fixed source order
// RULE18: resolve every cycle; detect plus five-cycle call
// RULE19: equal or higher routine blocks until return done
// RULE20: track in-service level, restore on return
module irq_handler
	import irq_pkg::*;
(
	input wire logic core_clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	irq_if.dev cpu_port, // to cpu sequencer
	input wire logic [irq_pkg::NUM_SRC-1:0] src_set, // peripheral event pulses
	input wire logic [irq_pkg::PIN_W-1:0] port_pins, // port pin levels, asynchronous
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest // stall
);
	import irq_pkg::*;

	logic [NUM_SRC-1:0] enable_r;
	logic global_irq_enable_r;
	logic [NUM_SRC-1:0] priority_r;
	logic [NUM_SRC-1:0] pending_r;
	logic [NUM_SRC-1:0] pending_eff;
	logic [NUM_SRC-1:0] pend_set;
	logic [NUM_SRC-1:0] pend_clr;
	logic [CFG_W-1:0] ext_irq_pin_config_r;
	logic [PIN_W-1:0] pin_s1_r;
	logic [PIN_W-1:0] pin_s2_r;
	logic [PIN_W-1:0] pin_s3_r;
	logic [PIN_W-1:0] pin_f_r;
	logic [1:0] ext_active;
	logic [1:0] ext_active_prev_r;
	logic [1:0] ext_edge_hit;
	logic ext0_edge_select;
	logic ext1_edge_select;
	logic ext0_polarity;
	logic ext1_polarity;
	logic low_act_r;
	logic high_act_r;
	logic req_r;
	logic src_high_r;
	logic [SRC_W-1:0] src_r;
	logic [VEC_W-1:0] vector_r;
	logic [NUM_SRC-1:0] armed;
	logic [NUM_SRC-1:0] eligible_hi;
	logic [NUM_SRC-1:0] eligible_lo;
	logic pick_valid;
	logic pick_high;
	logic [SRC_W-1:0] pick_src;
	logic wr_en;
	logic rd_valid_r;
	logic [31:0] rd_mux;

	assign ext0_edge_select = ext_irq_pin_config_r[CFG_EXT0_EDGE];
	assign ext1_edge_select = ext_irq_pin_config_r[CFG_EXT1_EDGE];
	assign ext0_polarity = ext_irq_pin_config_r[CFG_EXT0_POL];
	assign ext1_polarity = ext_irq_pin_config_r[CFG_EXT1_POL];

	// pin filter: a change counts once stages two and three agree
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			pin_s3_r <= '0;
			pin_f_r <= '0;
		end else begin
			pin_s1_r <= port_pins;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_f_r <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));
		end
	end

	// pin select is independent of crossbar; only reads the pin [RULE10]
	always_comb begin
		ext_active[0] = pin_f_r[ext_irq_pin_config_r[CFG_EXT0_PSEL +: PSEL_W]] == ext0_polarity; // [RULE9]
		ext_active[1] = pin_f_r[ext_irq_pin_config_r[CFG_EXT1_PSEL +: PSEL_W]] == ext1_polarity; // [RULE9]
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ext_active_prev_r <= 2'h3;
		end else begin
			ext_active_prev_r <= ext_active;
		end
	end

	// prev resets active so no false edge right after reset
	assign ext_edge_hit[0] = ext0_edge_select && ext_active[0] && !ext_active_prev_r[0]; // [RULE9]
	assign ext_edge_hit[1] = ext1_edge_select && ext_active[1] && !ext_active_prev_r[1]; // [RULE9]

	// level mode flags follow the input instead of latching
	always_comb begin
		pending_eff = pending_r;
		if (!ext0_edge_select) begin
			pending_eff[SRC_EXT0] = ext_active[0]; // [RULE13]
		end
		if (!ext1_edge_select) begin
			pending_eff[SRC_EXT1] = ext_active[1]; // [RULE13]
		end
	end

	assign wr_en = avs_write && !avs_read;

	always_comb begin
		pend_set = src_set; // [RULE1]
		pend_set[SRC_EXT0] = pend_set[SRC_EXT0] | ext_edge_hit[0];
		pend_set[SRC_EXT1] = pend_set[SRC_EXT1] | ext_edge_hit[1];
		pend_clr = '0;
		if (wr_en && avs_address == REG_PENDING) begin
			pend_set = pend_set | avs_writedata[NUM_SRC-1:0]; // [RULE8]
			pend_clr = ~avs_writedata[NUM_SRC-1:0]; // [RULE6]
		end
		if (cpu_port.ack) begin
			pend_clr[src_r] = pend_clr[src_r] | HW_CLEAR_MASK[src_r]; // [RULE6] [RULE12]
		end
	end

	// a set in the same cycle as a clear wins
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pending_r <= '0;
		end else begin
			pending_r <= (pending_r & ~pend_clr) | pend_set; // [RULE1]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			enable_r <= ENABLE_RST;
			global_irq_enable_r <= 1'b0;
			priority_r <= PRIORITY_RST; // [RULE16]
			ext_irq_pin_config_r <= EXT_CFG_RST;
		end else if (wr_en) begin
			case (avs_address)
				REG_ENABLE: enable_r <= avs_writedata[NUM_SRC-1:0];
				REG_GLOBAL: global_irq_enable_r <= avs_writedata[0];
				REG_PRIORITY: priority_r <= avs_writedata[NUM_SRC-1:0]; // [RULE15]
				REG_EXT_CFG: ext_irq_pin_config_r <= avs_writedata[CFG_W-1:0];
				default: ;
			endcase
		end
	end

	// masking and level gating
	assign armed = pending_eff & enable_r & {NUM_SRC{global_irq_enable_r}}; // [RULE4] [RULE5]
	assign eligible_hi = (high_act_r) ? '0 : (armed & priority_r); // [RULE15] [RULE19]
	assign eligible_lo = (high_act_r || low_act_r) ? '0 : (armed & ~priority_r); // [RULE19]

	// high level first, then lowest index within a level
	always_comb begin
		pick_valid = 1'b0;
		pick_high = 1'b0;
		pick_src = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (eligible_lo[i]) begin
				pick_valid = 1'b1;
				pick_src = SRC_W'(i); // [RULE17]
			end
		end
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (eligible_hi[i]) begin
				pick_valid = 1'b1;
				pick_high = 1'b1;
				pick_src = SRC_W'(i); // [RULE17]
			end
		end
	end

	// one detection cycle: request is registered every clock
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			req_r <= 1'b0;
			src_r <= '0;
			src_high_r <= 1'b0;
			vector_r <= VEC_BASE;
		end else begin
			req_r <= pick_valid && !cpu_port.ack; // [RULE2] [RULE18] [RULE7]
			src_r <= pick_src;
			src_high_r <= pick_high;
			vector_r <= VEC_BASE + (VEC_W'(pick_src) << VEC_STEP_SHIFT); // [RULE2]
		end
	end

	// in-service levels; return drops the highest one active
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			low_act_r <= 1'b0;
			high_act_r <= 1'b0;
		end else if (cpu_port.ack) begin
			if (src_high_r) begin
				high_act_r <= 1'b1; // [RULE20]
			end else begin
				low_act_r <= 1'b1; // [RULE20]
			end
		end else if (cpu_port.return_from_isr) begin
			if (high_act_r) begin
				high_act_r <= 1'b0; // [RULE20] [RULE3]
			end else begin
				low_act_r <= 1'b0; // [RULE20] [RULE3]
			end
		end
	end

	assign cpu_port.req = req_r;
	assign cpu_port.src = src_r;
	assign cpu_port.src_high = src_high_r;
	assign cpu_port.vector = vector_r;

	always_comb begin
		case (avs_address)
			REG_ENABLE: rd_mux = {15'h0000, enable_r};
			REG_GLOBAL: rd_mux = {31'h00000000, global_irq_enable_r};
			REG_PRIORITY: rd_mux = {15'h0000, priority_r};
			REG_PENDING: rd_mux = {15'h0000, pending_eff};
			REG_EXT_CFG: rd_mux = {21'h000000, ext_irq_pin_config_r};
			REG_STATUS: rd_mux = {19'h00000, src_r, 5'h00, req_r, high_act_r, low_act_r};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// reads take one wait cycle so read data come from a flip-flop
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_valid_r <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else begin
			rd_valid_r <= avs_read && !rd_valid_r;
			if (avs_read && !rd_valid_r) begin
				avs_readdata <= rd_mux;
			end
		end
	end

	assign avs_waitrequest = avs_read && !rd_valid_r;
endmodule

/* design/cpu_irq_sequencer.sv */
`timescale 1ns/1ps
module cpu_irq_sequencer
	import irq_pkg::*;
(
	input wire logic core_clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	irq_if.cpu irq_port, // to interrupt handler
	input wire logic instr_done, // instruction completes, pulse
	input wire logic instr_is_return_from_isr, // that instruction is a return
	output logic call_active, // vector call in progress
	output logic call_done, // call finished, pulse
	output logic [irq_pkg::VEC_W-1:0] call_addr // target of the call
);
	import irq_pkg::*;

	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_CALL = 2'b10
	} seq_state_t;

	seq_state_t state_r;
	logic [CALL_CNT_W-1:0] cnt_r;
	logic boundary;
	logic take;

	// the end of a return is no interrupt point; the next boundary is, so one instruction runs first
	assign boundary = instr_done && !instr_is_return_from_isr; // [RULE19] [RULE7]
	assign take = (state_r == ST_RUN) && boundary && irq_port.req; // [RULE2]

	assign irq_port.ack = take;
	assign irq_port.return_from_isr = (state_r == ST_RUN) && instr_done && instr_is_return_from_isr; // [RULE3]
	assign irq_port.instr_done = instr_done;
	assign call_active = (state_r == ST_CALL);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= ST_RUN;
			cnt_r <= '0;
			call_done <= 1'b0;
			call_addr <= '0;
		end else begin
			call_done <= 1'b0;
			case (state_r)
				ST_RUN: begin
					if (take) begin
						state_r <= ST_CALL;
						cnt_r <= '0;
						call_addr <= irq_port.vector;
					end
				end
				ST_CALL: begin
					if (cnt_r == CALL_LAST) begin
						state_r <= ST_RUN; // [RULE18]
						call_done <= 1'b1;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				default: state_r <= ST_RUN;
			endcase
		end
	end
endmodule

/* tb/irq_link_asserts.sv */
`timescale 1ns/1ps
module irq_link_asserts
	import irq_pkg::*;
(
	input wire logic core_clk, // clock
	input wire logic rst_n, // reset, active low
	input wire logic req, // request
	input wire logic [irq_pkg::VEC_W-1:0] vector, // call target
	input wire logic [irq_pkg::SRC_W-1:0] src, // winning source
	input wire logic src_high, // winner level
	input wire logic ack, // vectoring now
	input wire logic return_from_isr, // return executed
	input wire logic instr_done // instruction boundary
);
	import irq_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// the call holds the sequencer busy, so no boundary acts meanwhile
	sequence call_quiet;
		(!ack && !return_from_isr) [*5];
	endsequence
	vec_map_a: assert property (req |-> vector == VEC_BASE + ({11'h000, src} << VEC_STEP_SHIFT))
		else $error("vector does not match source");
	ack_cause_a: assert property (ack |-> req && instr_done)
		else $error("ack without request at a boundary");
	ack_return_from_isr_a: assert property (!(ack && return_from_isr))
		else $error("ack and return together");
	req_drop_a: assert property (ack |=> !req)
		else $error("request kept after ack");
	call_busy_a: assert property (ack |=> call_quiet)
		else $error("activity during vector call");
	// a request still standing after a return is taken at the next boundary
	reenter_a: assert property (return_from_isr ##[1:2] (instr_done && req && !return_from_isr) |-> ack)
		else $error("no re-entry after return");
	src_range_a: assert property (req |-> src < NUM_SRC)
		else $error("source index out of range");
	reset_idle_a: assert property ($rose(rst_n) |-> !req && !ack)
		else $error("request right after reset");
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
	import irq_pkg::*;
	logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, instr_done, instr_is_return_from_isr, call_active, call_done;
	logic [NUM_SRC-1:0] src_set;
	logic [7:0] port_pins, avs_address;
	logic [31:0] avs_writedata, avs_readdata, d;
	logic [VEC_W-1:0] call_addr;
	logic a;
	int miscompares = 0;
	int checked = 0;
	irq_if bus();
	irq_handler i_irq_handler(.core_clk(core_clk), .rst_n(rst_n), .cpu_port(bus), .src_set(src_set),
		.port_pins(port_pins), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	cpu_irq_sequencer i_cpu_irq_sequencer(.core_clk(core_clk), .rst_n(rst_n), .irq_port(bus),
		.instr_done(instr_done), .instr_is_return_from_isr(instr_is_return_from_isr), .call_active(call_active),
		.call_done(call_done), .call_addr(call_addr));
	irq_link_asserts i_irq_link_asserts(.core_clk(core_clk), .rst_n(rst_n), .req(bus.req), .vector(bus.vector),
		.src(bus.src), .src_high(bus.src_high), .ack(bus.ack), .return_from_isr(bus.return_from_isr), .instr_done(bus.instr_done));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic close_out;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic rst;
		rst_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		avs_address <= ad;
		avs_writedata <= wd;
		avs_write <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] ad);
		avs_address <= ad;
		avs_read <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic step(input logic r);
		instr_done <= 1'b1;
		instr_is_return_from_isr <= r;
		@(posedge core_clk);
		a = bus.ack;
		instr_done <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic enter(input logic [VEC_W-1:0] va);
		int n;
		step(1'b0);
		`CHK("ack", 1'b1, a)
		`CHK("call_active", 1'b1, call_active)
		n = 0;
		while (n < 8 && call_done !== 1'b1) begin
			@(posedge core_clk);
			n++;
		end
		`CHK("call_cycles", CALL_CYCLES, n)
		`CHK("call_idle", 1'b0, call_active)
		`CHK("call_addr", va, call_addr)
	endtask
	task automatic t_basic;
		rd(REG_PRIORITY);
		`CHK("prio_rst", 32'h0, d)
		wr(REG_GLOBAL, 32'h1);
		src_set <= 17'h00020;
		@(posedge core_clk);
		src_set <= '0;
		rd(REG_PENDING);
		`CHK("pend5", 1'b1, d[5])
		`CHK("req_off", 1'b0, bus.req)
		wr(REG_GLOBAL, 32'h0);
		wr(REG_ENABLE, 32'h20);
		// request is registered one edge after the write lands
		@(posedge core_clk);
		`CHK("req_global", 1'b0, bus.req)
		wr(REG_GLOBAL, 32'h1);
		@(posedge core_clk);
		`CHK("req_on", 1'b1, bus.req)
		enter(16'h002b);
		rd(REG_PENDING);
		`CHK("pend5_kept", 1'b1, d[5])
		step(1'b1);
		`CHK("return_from_isr_no_ack", 1'b0, a)
		enter(16'h002b);
	endtask
	task automatic t_prio;
		wr(REG_GLOBAL, 32'h1);
		wr(REG_ENABLE, 32'h2a0);
		wr(REG_PRIORITY, 32'h80);
		wr(REG_PENDING, 32'h0a0);
		@(posedge core_clk);
		`CHK("src_hi", 5'h07, bus.src)
		`CHK("src_high", 1'b1, bus.src_high)
		wr(REG_PRIORITY, 32'h0);
		@(posedge core_clk);
		`CHK("src_order", 5'h05, bus.src)
		enter(16'h002b);
		wr(REG_PENDING, 32'h80);
		wr(REG_PRIORITY, 32'h280);
		enter(16'h003b);
		wr(REG_PENDING, 32'h200);
		step(1'b0);
		`CHK("no_preempt", 1'b0, a)
		step(1'b1);
		rd(REG_STATUS);
		`CHK("in_service", 2'b01, d[1:0])
		enter(16'h004b);
		`CHK("preempt_low", 1'b1, a)
		rd(REG_STATUS);
		`CHK("both_service", 2'b11, d[1:0])
	endtask
	task automatic t_ext;
		wr(REG_EXT_CFG, 32'h004);
		port_pins <= 8'h01;
		repeat (6) @(posedge core_clk);
		rd(REG_PENDING);
		`CHK("lvl_on", 1'b1, d[0])
		port_pins <= 8'h00;
		repeat (6) @(posedge core_clk);
		rd(REG_PENDING);
		`CHK("lvl_off", 1'b0, d[0])
		wr(REG_EXT_CFG, 32'h302);
		// released open-drain pin idles high, active low pulls it down
		port_pins <= 8'h08;
		repeat (6) @(posedge core_clk);
		port_pins <= 8'h00;
		repeat (6) @(posedge core_clk);
		port_pins <= 8'h08;
		repeat (6) @(posedge core_clk);
		rd(REG_PENDING);
		`CHK("edge_latch", 1'b1, d[2])
		`CHK("lvl_low", 1'b1, d[0])
		wr(REG_ENABLE, 32'h4);
		wr(REG_GLOBAL, 32'h1);
		enter(16'h0013);
		rd(REG_PENDING);
		`CHK("edge_clr", 1'b0, d[2])
		// ext0 rising edge on pin 0, ext1 level active high on the same pin
		wr(REG_EXT_CFG, 32'h00d);
		port_pins <= 8'h01;
		repeat (6) @(posedge core_clk);
		step(1'b1);
		enter(16'h0013);
		port_pins <= 8'h00;
		repeat (6) @(posedge core_clk);
		rd(REG_PENDING);
		`CHK("edge_hold", 1'b1, d[0])
		`CHK("lvl_release", 1'b0, d[2])
	endtask
	initial begin
		#200000;
		miscompares++;
		close_out;
	end
	initial begin
		rst_n = 1'b0;
		src_set = '0;
		port_pins = 8'h00;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		instr_done = 1'b0;
		instr_is_return_from_isr = 1'b0;
		rst;
		t_basic;
		rst;
		t_prio;
		rst;
		t_ext;
		close_out;
	end
endmodule
